/* File: rtl/bspc_pkg.sv */
// package of constants for the buffered serial pin control block
package bspc_pkg;
    localparam int BSPC_NUM_PORTS = 3;
    localparam int BSPC_WORD_BITS = 16;
    // register byte offsets, one block of four words per port
    localparam logic [7:0] BSPC_PORT_STRIDE = 8'h10;
    localparam logic [3:0] BSPC_OFS_PINCTRL = 4'h0;
    localparam logic [3:0] BSPC_OFS_TXDATA = 4'h4;
    localparam logic [3:0] BSPC_OFS_RXDATA = 4'h8;
    localparam logic [3:0] BSPC_OFS_STATUS = 4'hc;
    // pin control fields
    localparam int BSPC_PC_RXCLKMODE = 0;
    localparam int BSPC_PC_TXCLKMODE = 1;
    localparam int BSPC_PC_TXFSOUT = 2;
    localparam int BSPC_PC_RXGPIO = 3;
    localparam int BSPC_PC_TXGPIO = 4;
    localparam int BSPC_PC_GPOUT = 8;
    localparam int BSPC_PC_GPOE = 16;
    localparam int BSPC_PC_CLKDIV = 24;
    localparam logic [31:0] BSPC_PC_RESET = 32'h0300_0000;
    // status fields
    localparam int BSPC_ST_RXFULL = 0;
    localparam int BSPC_ST_TXBUSY = 1;
    localparam int BSPC_ST_GPIN = 8;
    // gpio bit order within a six bit field
    localparam int BSPC_G_RCLK = 0;
    localparam int BSPC_G_RDAT = 1;
    localparam int BSPC_G_RFS = 2;
    localparam int BSPC_G_XCLK = 3;
    localparam int BSPC_G_XDAT = 4;
    localparam int BSPC_G_XFS = 5;
endpackage

/* File: rtl/bspc_port.sv */
// one serial port lane: shift logic on the serial clock; pin muxing sits in bspc_top
`timescale 1ns/1ps
module bspc_port
    import bspc_pkg::*;
#(
    parameter int WORD_BITS = BSPC_WORD_BITS
) (
    input wire logic serClk,
    input wire logic serRst,
    input wire logic rxClkMode,
    input wire logic txClkMode,
    input wire logic txFsOut,
    input wire logic rxGpio,
    input wire logic txGpio,
    input wire logic txReqTgl,
    input wire logic [WORD_BITS-1:0] txWord,
    output logic txAckTgl,
    output logic rxDoneTgl,
    output logic [WORD_BITS-1:0] rxWord,
    input wire logic rxDataIn,
    input wire logic rxFsIn,
    input wire logic txFsIn,
    output logic txDataOut,
    output logic txFsDrive
);
    typedef enum logic [1:0] {SH_IDLE, SH_RUN} bspc_shift_t;
    localparam int CW = $clog2(WORD_BITS + 1);

    bspc_shift_t rxSt_ff, nxt_rxSt, txSt_ff, nxt_txSt;
    logic [CW-1:0] rxCnt_ff, nxt_rxCnt, txCnt_ff, nxt_txCnt;
    logic [WORD_BITS-1:0] rxSh_ff, nxt_rxSh, rxWord_ff, nxt_rxWord, txSh_ff, nxt_txSh;
    logic rxDone_ff, nxt_rxDone, txAck_ff, nxt_txAck, txFs_ff, nxt_txFs;
    logic [1:0] reqSync_ff, nxt_reqSync;
    logic txData_ff, nxt_txData;
    logic fsStart;
    logic [WORD_BITS-1:0] txWordHold_ff, nxt_txWordHold;

    // tx frame sync comes from our own pulse or from the far side
    assign fsStart = txFsOut ? txFs_ff : txFsIn;

    always_comb begin
        nxt_rxSt = rxSt_ff;
        nxt_rxCnt = rxCnt_ff;
        nxt_rxSh = rxSh_ff;
        nxt_rxWord = rxWord_ff;
        nxt_rxDone = rxDone_ff;
        case (rxSt_ff)
            SH_IDLE: begin
                if (!rxGpio && rxFsIn) begin
                    nxt_rxSt = SH_RUN;
                    nxt_rxCnt = '0;
                end
            end
            SH_RUN: begin
                nxt_rxSh = {rxSh_ff[WORD_BITS-2:0], rxDataIn};
                nxt_rxCnt = rxCnt_ff + 1'b1;
                if (rxCnt_ff == CW'(WORD_BITS - 1)) begin
                    nxt_rxSt = SH_IDLE;
                    nxt_rxWord = {rxSh_ff[WORD_BITS-2:0], rxDataIn};
                    nxt_rxDone = ~rxDone_ff;
                end
            end
            default: nxt_rxSt = SH_IDLE;
        endcase
    end

    always_comb begin
        nxt_txSt = txSt_ff;
        nxt_txCnt = txCnt_ff;
        nxt_txSh = txSh_ff;
        nxt_txAck = txAck_ff;
        nxt_txData = txData_ff;
        nxt_txFs = 1'b0;
        nxt_reqSync = {reqSync_ff[0], txReqTgl};
        nxt_txWordHold = txWordHold_ff;
        case (txSt_ff)
            SH_IDLE: begin
                // word is stable while the request toggle is in flight
                if (reqSync_ff[1] != txAck_ff && !txGpio) begin
                    nxt_txFs = txFsOut & ~txFs_ff;
                    nxt_txWordHold = txWord;
                    if (fsStart) begin
                        nxt_txSt = SH_RUN;
                        nxt_txCnt = '0;
                        nxt_txSh = txWordHold_ff;
                    end
                end
            end
            SH_RUN: begin
                nxt_txData = txSh_ff[WORD_BITS-1];
                nxt_txSh = {txSh_ff[WORD_BITS-2:0], 1'b0};
                nxt_txCnt = txCnt_ff + 1'b1;
                if (txCnt_ff == CW'(WORD_BITS - 1)) begin
                    nxt_txSt = SH_IDLE;
                    nxt_txAck = ~txAck_ff;
                end
            end
            default: nxt_txSt = SH_IDLE;
        endcase
    end

    always_ff @(posedge serClk) begin
        if (serRst) begin
            rxSt_ff <= SH_IDLE;
            txSt_ff <= SH_IDLE;
            rxCnt_ff <= '0;
            txCnt_ff <= '0;
            rxSh_ff <= '0;
            rxWord_ff <= '0;
            txSh_ff <= '0;
            rxDone_ff <= 1'b0;
            txAck_ff <= 1'b0;
            txFs_ff <= 1'b0;
            reqSync_ff <= '0;
            txData_ff <= 1'b0;
            txWordHold_ff <= '0;
        end else begin
            rxSt_ff <= nxt_rxSt;
            txSt_ff <= nxt_txSt;
            rxCnt_ff <= nxt_rxCnt;
            txCnt_ff <= nxt_txCnt;
            rxSh_ff <= nxt_rxSh;
            rxWord_ff <= nxt_rxWord;
            txSh_ff <= nxt_txSh;
            rxDone_ff <= nxt_rxDone;
            txAck_ff <= nxt_txAck;
            txFs_ff <= nxt_txFs;
            reqSync_ff <= nxt_reqSync;
            txData_ff <= nxt_txData;
            txWordHold_ff <= nxt_txWordHold;
        end
    end

    assign txAckTgl = txAck_ff;
    assign rxDoneTgl = rxDone_ff;
    assign rxWord = rxWord_ff;
    assign txDataOut = txData_ff;
    assign txFsDrive = txFs_ff;

    a_tx_fs_start: assert property (@(posedge serClk) disable iff (serRst)
        (txSt_ff == SH_IDLE && fsStart && reqSync_ff[1] != txAck_ff && !txGpio) |=> txSt_ff == SH_RUN)
        else $error("tx frame sync did not start shifting");
    a_rx_fs_start: assert property (@(posedge serClk) disable iff (serRst)
        (rxSt_ff == SH_IDLE && rxFsIn && !rxGpio) |=> rxSt_ff == SH_RUN)
        else $error("rx frame sync did not start reception");
    a_rx_word_len: assert property (@(posedge serClk) disable iff (serRst)
        $rose(rxSt_ff == SH_RUN) |-> rxCnt_ff == '0 ##15 (rxSt_ff == SH_RUN && rxCnt_ff == CW'(WORD_BITS - 1))
            ##1 rxSt_ff == SH_IDLE)
        else $error("receive word length wrong");
    a_tx_shift_bit: assert property (@(posedge serClk) disable iff (serRst)
        (txSt_ff == SH_RUN) |=> txData_ff == $past(txSh_ff[WORD_BITS-1]))
        else $error("tx data not shifted from msb");
endmodule

/* File: rtl/bspc_sync2.sv */
// two flop synchroniser for levels, WIDTH bits wide, each bit synchronised on its own
`timescale 1ns/1ps
module bspc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_sync;

    always_comb begin
        nxt_meta = din;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign dout = sync_ff;
endmodule

/* File: rtl/bspc_top.sv */
// three buffered serial ports with pin direction control and an ahb-lite register slave
`timescale 1ns/1ps
module bspc_top
    import bspc_pkg::*;
#(
    parameter int NUM_PORTS = BSPC_NUM_PORTS,
    parameter int WORD_BITS = BSPC_WORD_BITS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chip_reset_n,
    input wire logic output_disable_n,
    input wire logic link_clk,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NUM_PORTS-1:0] rx_shift_clock_pin_i,
    output logic [NUM_PORTS-1:0] rx_shift_clock_pin_o,
    output logic [NUM_PORTS-1:0] rx_shift_clock_pin_oe_n,
    input wire logic [NUM_PORTS-1:0] rx_data_pin_i,
    output logic [NUM_PORTS-1:0] rx_data_pin_o,
    output logic [NUM_PORTS-1:0] rx_data_pin_oe_n,
    input wire logic [NUM_PORTS-1:0] rx_frame_sync_pin_i,
    output logic [NUM_PORTS-1:0] rx_frame_sync_pin_o,
    output logic [NUM_PORTS-1:0] rx_frame_sync_pin_oe_n,
    input wire logic [NUM_PORTS-1:0] tx_shift_clock_pin_i,
    output logic [NUM_PORTS-1:0] tx_shift_clock_pin_o,
    output logic [NUM_PORTS-1:0] tx_shift_clock_pin_oe_n,
    input wire logic [NUM_PORTS-1:0] tx_data_pin_i,
    output logic [NUM_PORTS-1:0] tx_data_pin_o,
    output logic [NUM_PORTS-1:0] tx_data_pin_oe_n,
    input wire logic [NUM_PORTS-1:0] tx_frame_sync_pin_i,
    output logic [NUM_PORTS-1:0] tx_frame_sync_pin_o,
    output logic [NUM_PORTS-1:0] tx_frame_sync_pin_oe_n
);
    // link domain reset: chip reset or system reset, synchronised to link_clk
    logic rstReq;
    logic linkRst;
    logic chipRstSync;
    assign rstReq = sys_rst | ~chipRstSync;

    bspc_sync2 #(.WIDTH(1)) uChipRst (
        .clk(clk),
        .rst(sys_rst),
        .din(~chip_reset_n),
        .dout()
    );
    // chip reset is a pin: two flops on clk before use
    logic [1:0] chipRs_ff, nxt_chipRs;
    always_comb nxt_chipRs = {chipRs_ff[0], chip_reset_n};
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chipRs_ff <= 2'b00;
        end else begin
            chipRs_ff <= nxt_chipRs;
        end
    end
    assign chipRstSync = chipRs_ff[1];

    logic [1:0] linkRst_ff, nxt_linkRst;
    always_comb nxt_linkRst = {linkRst_ff[0], rstReq};
    // reset must be held at least three link clock edges
    always_ff @(posedge link_clk) begin
        linkRst_ff <= nxt_linkRst;
    end
    assign linkRst = linkRst_ff[1];

    logic [1:0] offSync_ff, nxt_offSync;
    always_comb nxt_offSync = {offSync_ff[0], output_disable_n};
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            offSync_ff <= 2'b00;
        end else begin
            offSync_ff <= nxt_offSync;
        end
    end

    // ahb-lite register slave, zero wait states
    logic [31:0] pinCtrl_ff [NUM_PORTS];
    logic [31:0] nxt_pinCtrl [NUM_PORTS];
    logic [WORD_BITS-1:0] txData_ff [NUM_PORTS];
    logic [WORD_BITS-1:0] nxt_txData [NUM_PORTS];
    logic [NUM_PORTS-1:0] txReq_ff, nxt_txReq, rxFull_ff, nxt_rxFull;
    logic [NUM_PORTS-1:0] txAckS, rxDoneS, rxDoneSeen_ff, nxt_rxDoneSeen;
    logic [WORD_BITS-1:0] rxWordL [NUM_PORTS];
    logic [WORD_BITS-1:0] rxHold_ff [NUM_PORTS];
    logic [WORD_BITS-1:0] nxt_rxHold [NUM_PORTS];
    logic [5:0] gpIn [NUM_PORTS];
    logic [7:0] dAddr_ff, nxt_dAddr;
    logic dWr_ff, nxt_dWr, dRd_ff, nxt_dRd;
    logic [31:0] rdata_ff, nxt_rdata;
    logic acc;
    logic [3:0] dPort;
    logic [3:0] dOfs;

    assign acc = hsel & hready & htrans[1];
    assign dPort = dAddr_ff[7:4];
    assign dOfs = dAddr_ff[3:0];

    always_comb begin
        nxt_dAddr = acc ? haddr[7:0] : dAddr_ff;
        nxt_dWr = acc & hwrite;
        nxt_dRd = acc & ~hwrite;
        nxt_txReq = txReq_ff;
        nxt_rxFull = rxFull_ff;
        nxt_rxDoneSeen = rxDoneS;
        nxt_rdata = 32'h0000_0000;
        for (int p = 0; p < NUM_PORTS; p++) begin
            nxt_pinCtrl[p] = pinCtrl_ff[p];
            nxt_txData[p] = txData_ff[p];
            nxt_rxHold[p] = rxHold_ff[p];
            if (dRd_ff && dPort == 4'(p) && dOfs == BSPC_OFS_RXDATA) begin
                nxt_rxFull[p] = 1'b0;
            end
            // a new word wins over the read that clears full
            if (rxDoneS[p] != rxDoneSeen_ff[p]) begin
                nxt_rxFull[p] = 1'b1;
                nxt_rxHold[p] = rxWordL[p];
            end
            if (dWr_ff && dPort == 4'(p)) begin
                if (dOfs == BSPC_OFS_PINCTRL) begin
                    nxt_pinCtrl[p] = hwdata;
                end
                if (dOfs == BSPC_OFS_TXDATA && txReq_ff[p] == txAckS[p]) begin
                    nxt_txData[p] = hwdata[WORD_BITS-1:0];
                    nxt_txReq[p] = ~txReq_ff[p];
                end
            end
            if (!chipRstSync && pinCtrl_ff[p][BSPC_PC_TXFSOUT]) begin
                nxt_pinCtrl[p][BSPC_PC_TXFSOUT] = 1'b0;
            end
            if (acc && !hwrite && haddr[7:4] == 4'(p)) begin
                case (haddr[3:0])
                    BSPC_OFS_PINCTRL: nxt_rdata = pinCtrl_ff[p];
                    BSPC_OFS_TXDATA: nxt_rdata = 32'(txData_ff[p]);
                    BSPC_OFS_RXDATA: nxt_rdata = 32'(rxHold_ff[p]);
                    BSPC_OFS_STATUS: nxt_rdata = {18'h0, gpIn[p], 6'h0,
                        txReq_ff[p] != txAckS[p], rxFull_ff[p]};
                    default: nxt_rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dAddr_ff <= 8'h00;
            dWr_ff <= 1'b0;
            dRd_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            txReq_ff <= '0;
            rxFull_ff <= '0;
            rxDoneSeen_ff <= '0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                pinCtrl_ff[p] <= BSPC_PC_RESET;
                txData_ff[p] <= '0;
                rxHold_ff[p] <= '0;
            end
        end else begin
            dAddr_ff <= nxt_dAddr;
            dWr_ff <= nxt_dWr;
            dRd_ff <= nxt_dRd;
            rdata_ff <= nxt_rdata;
            txReq_ff <= nxt_txReq;
            rxFull_ff <= nxt_rxFull;
            rxDoneSeen_ff <= nxt_rxDoneSeen;
            for (int p = 0; p < NUM_PORTS; p++) begin
                pinCtrl_ff[p] <= nxt_pinCtrl[p];
                txData_ff[p] <= nxt_txData[p];
                rxHold_ff[p] <= nxt_rxHold[p];
            end
        end
    end

    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // per-port instances and pin muxing
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : gPort
            logic rxG, txG, en, txFsDrv, txDat;
            logic [5:0] gpRaw, gpS;
            logic rxDataL, rxFsL, txFsL;
            assign rxG = pinCtrl_ff[g][BSPC_PC_RXGPIO];
            assign txG = pinCtrl_ff[g][BSPC_PC_TXGPIO];
            assign en = offSync_ff[1];
            assign gpRaw = {tx_frame_sync_pin_i[g], tx_data_pin_i[g], tx_shift_clock_pin_i[g],
                rx_frame_sync_pin_i[g], rx_data_pin_i[g], rx_shift_clock_pin_i[g]};

            bspc_sync2 #(.WIDTH(6)) uGpIn (.clk(clk), .rst(sys_rst), .din(gpRaw), .dout(gpS));
            assign gpIn[g] = gpS;
            // link data and frame syncs: two flops on the link clock
            bspc_sync2 #(.WIDTH(3)) uLinkIn (.clk(link_clk), .rst(linkRst),
                .din({tx_frame_sync_pin_i[g], rx_frame_sync_pin_i[g], rx_data_pin_i[g]}),
                .dout({txFsL, rxFsL, rxDataL}));
            logic txAckL, rxDoneL, rxGL, txGL, txFsOutL;
            // handshake toggles back into clk domain
            bspc_sync2 #(.WIDTH(2)) uTglSync (.clk(clk), .rst(sys_rst),
                .din({txAckL, rxDoneL}), .dout({txAckS[g], rxDoneS[g]}));
            // txfsout and gpio mode bits are quasi static, but still cross into the link domain; clock mode bits go to the port unsynchronised
            bspc_sync2 #(.WIDTH(3)) uCfgSync (.clk(link_clk), .rst(linkRst),
                .din({pinCtrl_ff[g][BSPC_PC_TXFSOUT], txG, rxG}), .dout({txFsOutL, txGL, rxGL}));
            bspc_port #(.WORD_BITS(WORD_BITS)) uPort (
                .serClk(link_clk),
                .serRst(linkRst),
                .rxClkMode(pinCtrl_ff[g][BSPC_PC_RXCLKMODE]),
                .txClkMode(pinCtrl_ff[g][BSPC_PC_TXCLKMODE]),
                .txFsOut(txFsOutL),
                .rxGpio(rxGL),
                .txGpio(txGL),
                .txReqTgl(txReq_ff[g]),
                .txWord(txData_ff[g]),
                .txAckTgl(txAckL),
                .rxDoneTgl(rxDoneL),
                .rxWord(rxWordL[g]),
                .rxDataIn(rxDataL),
                .rxFsIn(rxFsL),
                .txFsIn(txFsL),
                .txDataOut(txDat),
                .txFsDrive(txFsDrv)
            );
            // gpio enables are active high in the field, pin enables active low
            always_comb begin
                rx_shift_clock_pin_o[g] = rxG ? pinCtrl_ff[g][BSPC_PC_GPOUT + BSPC_G_RCLK] : link_clk;
                rx_shift_clock_pin_oe_n[g] = rxG ? ~pinCtrl_ff[g][BSPC_PC_GPOE + BSPC_G_RCLK]
                    : ~pinCtrl_ff[g][BSPC_PC_RXCLKMODE];
                rx_data_pin_o[g] = pinCtrl_ff[g][BSPC_PC_GPOUT + BSPC_G_RDAT];
                rx_data_pin_oe_n[g] = ~(rxG & pinCtrl_ff[g][BSPC_PC_GPOE + BSPC_G_RDAT]);
                rx_frame_sync_pin_o[g] = pinCtrl_ff[g][BSPC_PC_GPOUT + BSPC_G_RFS];
                rx_frame_sync_pin_oe_n[g] = ~(rxG & pinCtrl_ff[g][BSPC_PC_GPOE + BSPC_G_RFS]);
                tx_shift_clock_pin_o[g] = txG ? pinCtrl_ff[g][BSPC_PC_GPOUT + BSPC_G_XCLK] : link_clk;
                tx_shift_clock_pin_oe_n[g] = ~en | (txG ? ~pinCtrl_ff[g][BSPC_PC_GPOE + BSPC_G_XCLK]
                    : ~pinCtrl_ff[g][BSPC_PC_TXCLKMODE]);
                tx_data_pin_o[g] = txG ? pinCtrl_ff[g][BSPC_PC_GPOUT + BSPC_G_XDAT] : txDat;
                tx_data_pin_oe_n[g] = ~en | (txG & ~pinCtrl_ff[g][BSPC_PC_GPOE + BSPC_G_XDAT]);
                tx_frame_sync_pin_o[g] = txG ? pinCtrl_ff[g][BSPC_PC_GPOUT + BSPC_G_XFS] : txFsDrv;
                tx_frame_sync_pin_oe_n[g] = ~en | (txG ? ~pinCtrl_ff[g][BSPC_PC_GPOE + BSPC_G_XFS]
                    : ~pinCtrl_ff[g][BSPC_PC_TXFSOUT]);
            end

            a_off_floats: assert property (@(posedge clk) disable iff (sys_rst)
                !en |-> tx_data_pin_oe_n[g] && tx_shift_clock_pin_oe_n[g] && tx_frame_sync_pin_oe_n[g])
                else $error("transmit pins driven while output disabled");
            a_rst_fs_input: assert property (@(posedge clk) disable iff (sys_rst)
                !chipRstSync |=> !pinCtrl_ff[g][BSPC_PC_TXFSOUT])
                else $error("tx frame sync still output after chip reset");
            a_rxclk_dir: assert property (@(posedge clk) disable iff (sys_rst)
                !rxG |-> rx_shift_clock_pin_oe_n[g] == !pinCtrl_ff[g][BSPC_PC_RXCLKMODE])
                else $error("receive clock direction wrong");
            a_txclk_dir: assert property (@(posedge clk) disable iff (sys_rst)
                (en && !txG && !pinCtrl_ff[g][BSPC_PC_TXCLKMODE]) |-> tx_shift_clock_pin_oe_n[g])
                else $error("transmit clock driven in input mode");
            a_gpio_rx: assert property (@(posedge clk) disable iff (sys_rst)
                rxG |-> rx_shift_clock_pin_oe_n[g] == !pinCtrl_ff[g][BSPC_PC_GPOE + BSPC_G_RCLK])
                else $error("receive clock direction wrong in gpio mode");
            a_gpio_tx: assert property (@(posedge clk) disable iff (sys_rst)
                (en && txG) |-> tx_data_pin_o[g] == pinCtrl_ff[g][BSPC_PC_GPOUT + BSPC_G_XDAT])
                else $error("transmit data not from gpio in gpio mode");
        end
    endgenerate
endmodule

/* File: sim/bspc_peer_model.sv */
// far-side serial peer: sends receive frames, records the transmit bits of port 0
`timescale 1ns/1ps
module bspc_peer_model (
    input wire logic linkClk,
    input wire logic [2:0] txDataPin,
    output logic [2:0] rxClkPin,
    output logic [2:0] rxDataPin,
    output logic [2:0] rxFsPin,
    output logic [2:0] txClkPin,
    output logic [2:0] txFsPin,
    output logic [63:0] txHist
);
    logic inFrame;
    initial begin
        inFrame = 1'b0;
        rxDataPin = 3'b000;
        rxFsPin = 3'b000;
        txFsPin = 3'b000;
        txHist = 64'h0;
    end
    // clocks stand still between frames
    assign rxClkPin = {3{inFrame & linkClk}};
    assign txClkPin = rxClkPin;
    always @(posedge linkClk) begin
        txHist <= {txHist[62:0], txDataPin[0]};
        if (!inFrame) begin
            rxDataPin <= ~rxDataPin;
        end
    end
    // one frame sync pulse, then the word msb first
    task automatic send_word(input int port, input logic [15:0] word);
        @(negedge linkClk);
        inFrame = 1'b1;
        rxFsPin[port] = 1'b1;
        @(negedge linkClk);
        rxFsPin[port] = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            rxDataPin[port] = word[i];
            @(negedge linkClk);
        end
        repeat (4) @(negedge linkClk);
        inFrame = 1'b0;
    endtask
endmodule

/* File: sim/buffered_serial_pin_control_test.sv */
// testbench: registers, pin direction, gpio and serial traffic
`timescale 1ns/1ps
module buffered_serial_pin_control_test;
    import bspc_pkg::*;
    localparam logic [31:0] PC_CLKS = (32'h1 << BSPC_PC_RXCLKMODE) | (32'h1 << BSPC_PC_TXCLKMODE);
    localparam logic [31:0] PC_FS = 32'h1 << BSPC_PC_TXFSOUT;
    logic clk = 1'b0, linkClk = 1'b0, sysRst = 1'b1, chipRstN = 1'b1, outDisN = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, found;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [2:0] rckI, rckO, rckN, rdI, rdO, rdN, rfI, rfO, rfN, xckI, xckO, xckN, xdI, xdO, xdN, xfI, xfO, xfN;
    logic [2:0] pRck, pRd, pRf, pXck, pXf;
    logic [63:0] hist;
    int n_errors = 0, compares = 0;
    always #2 clk = ~clk;
    initial begin
        #1.3;
        forever #6 linkClk = ~linkClk;
    end
    assign rckI = rckN & pRck | ~rckN & rckO;
    assign rdI = rdN & pRd | ~rdN & rdO;
    assign rfI = rfN & pRf | ~rfN & rfO;
    assign xckI = xckN & pXck | ~xckN & xckO;
    assign xdI = xdO ^ xdN; // released line shows the inverse of its last level
    assign xfI = xfN & pXf | ~xfN & xfO;
    bspc_top dut_u (.clk(clk), .sys_rst(sysRst), .chip_reset_n(chipRstN), .output_disable_n(outDisN),
        .link_clk(linkClk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_shift_clock_pin_i(rckI), .rx_shift_clock_pin_o(rckO), .rx_shift_clock_pin_oe_n(rckN),
        .rx_data_pin_i(rdI), .rx_data_pin_o(rdO), .rx_data_pin_oe_n(rdN),
        .rx_frame_sync_pin_i(rfI), .rx_frame_sync_pin_o(rfO), .rx_frame_sync_pin_oe_n(rfN),
        .tx_shift_clock_pin_i(xckI), .tx_shift_clock_pin_o(xckO), .tx_shift_clock_pin_oe_n(xckN),
        .tx_data_pin_i(xdI), .tx_data_pin_o(xdO), .tx_data_pin_oe_n(xdN),
        .tx_frame_sync_pin_i(xfI), .tx_frame_sync_pin_o(xfO), .tx_frame_sync_pin_oe_n(xfN));
    bspc_peer_model peer_u (.linkClk(linkClk), .txDataPin(xdI), .rxClkPin(pRck), .rxDataPin(pRd),
        .rxFsPin(pRf), .txClkPin(pXck), .txFsPin(pXf), .txHist(hist));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic wr, input int p, input logic [3:0] ofs, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= 32'(p) * 32'(BSPC_PORT_STRIDE) + 32'(ofs);
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic setpc(input int p, input logic [31:0] v);
        xfer(1'b1, p, BSPC_OFS_PINCTRL, v);
        repeat (2) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            xfer(1'b0, p, BSPC_OFS_PINCTRL, 32'h0);
            check(rd, BSPC_PC_RESET);
        end
        check({rckN, xckN, xfN, xdN}, 12'hff8);
        xfer(1'b1, 3, BSPC_OFS_PINCTRL, 32'hffffffff);
        xfer(1'b0, 3, BSPC_OFS_PINCTRL, 32'h0);
        check(rd, 32'h0);
        for (int p = 0; p < 3; p++) begin
            setpc(p, BSPC_PC_RESET | PC_CLKS);
            check({rckN, xckN}, {~(3'b001 << p), ~(3'b001 << p)});
            setpc(p, BSPC_PC_RESET);
            check({rckN, xckN}, 6'h3f);
        end
        $display("test direction done");
        setpc(0, BSPC_PC_RESET | PC_CLKS | PC_FS);
        check({xckN[0], xfN[0]}, 2'b00);
        outDisN <= 1'b0;
        repeat (4) @(posedge clk);
        check({xckN, xdN, xfN}, 9'h1ff);
        outDisN <= 1'b1;
        repeat (4) @(posedge clk);
        check(xfN[0], 1'b0);
        chipRstN <= 1'b0;
        repeat (5) @(posedge clk);
        chipRstN <= 1'b1;
        repeat (4) @(posedge clk);
        check(xfN[0], 1'b1);
        xfer(1'b0, 0, BSPC_OFS_PINCTRL, 32'h0);
        check(rd[BSPC_PC_TXFSOUT], 1'b0);
        $display("test disable and reset done");
        setpc(2, BSPC_PC_RESET | (32'h1 << BSPC_PC_RXGPIO) | (32'h5 << BSPC_PC_GPOUT) | (32'h7 << BSPC_PC_GPOE));
        check({rckN[2], rdN[2], rfN[2], rfO[2], rdO[2], rckO[2]}, 6'b000101);
        setpc(2, BSPC_PC_RESET | (32'h1 << BSPC_PC_TXGPIO) | (32'h28 << BSPC_PC_GPOUT) | (32'h38 << BSPC_PC_GPOE));
        check({xckN[2], xdN[2], xfN[2], xfO[2], xdO[2], xckO[2]}, 6'b000101);
        repeat (4) @(posedge clk);
        xfer(1'b0, 2, BSPC_OFS_STATUS, 32'h0);
        check(rd[13:11], 3'b101);
        setpc(2, BSPC_PC_RESET);
        $display("test gpio done");
        setpc(0, BSPC_PC_RESET | PC_CLKS | PC_FS);
        xfer(1'b1, 0, BSPC_OFS_TXDATA, 32'ha5c3);
        xfer(1'b0, 0, BSPC_OFS_STATUS, 32'h0);
        check(rd[BSPC_ST_TXBUSY], 1'b1);
        for (int i = 0; i < 100 && rd[BSPC_ST_TXBUSY] !== 1'b0; i++) begin
            xfer(1'b0, 0, BSPC_OFS_STATUS, 32'h0);
        end
        check(rd[BSPC_ST_TXBUSY], 1'b0);
        found = 1'b0;
        for (int i = 0; i < 48; i++) begin
            if (hist[i +: 16] === 16'ha5c3) found = 1'b1;
        end
        check(found, 1'b1);
        $display("test transmit done");
        for (int p = 0; p < 3; p++) begin
            peer_u.send_word(p, 16'h3c90 + 16'(p));
            @(posedge clk);
            rd = 32'h0;
            for (int i = 0; i < 50 && rd[BSPC_ST_RXFULL] !== 1'b1; i++) begin
                xfer(1'b0, p, BSPC_OFS_STATUS, 32'h0);
            end
            xfer(1'b0, p, BSPC_OFS_RXDATA, 32'h0);
            check(rd, {16'h0, 16'h3c90 + 16'(p)});
            xfer(1'b0, p, BSPC_OFS_STATUS, 32'h0);
            check(rd[BSPC_ST_RXFULL], 1'b0);
        end
        $display("test receive done");
        finish_test();
    end
endmodule
